// ==== verif/spacewire_wormhole_routing_core_bench.sv ====
// self-checking bench for the routing core
`timescale 1ns/1ps
module spacewire_wormhole_routing_core_bench
  import swrc_pkg::*;
;
  // ======
  // design ports and far-end controls
  logic                     clk_i, rst_i, ce_i, spw_clk_i, rt_wr_i, rt_wr_del_i, rt_rd_del_o;
  logic                     router_config_reset_bit_i;
  logic [7:0]               rt_wr_addr_i, rt_rd_addr_i;
  logic [NP-1:0]            lrx_valid_i, lrx_ready_o, ltx_valid_o, ltx_ready_i, got_null_i;
  logic [NP-1:0]            got_fct_i, link_err_i, drv_en_o, tx_null_o, tx_fct_o, link_run_o;
  logic [NP-1:0]            autostart_i, port_link_disable_bit_i, ovr_to_en_i, rt_wr_mask_i;
  logic [NP-1:0]            rt_rd_mask_o, out_busy_o, stall, fail;
  logic [NP-1:0][SYM_W-1:0] lrx_data_i, ltx_data_o;
  int                       err_count, checks;

  swrc_core u_dut (.clk_i, .rst_i, .ce_i, .spw_clk_i, .lrx_valid_i, .lrx_data_i, .lrx_ready_o,
    .ltx_valid_o, .ltx_data_o, .ltx_ready_i, .got_null_i, .got_fct_i, .link_err_i, .drv_en_o,
    .tx_null_o, .tx_fct_o, .link_run_o, .autostart_i, .port_link_disable_bit_i,
    .router_config_reset_bit_i, .ovr_to_en_i, .rt_wr_i, .rt_wr_addr_i, .rt_wr_mask_i,
    .rt_wr_del_i, .rt_rd_addr_i, .rt_rd_mask_o, .rt_rd_del_o, .out_busy_o);
  swrc_far_end u_far (.spw_clk_i, .drv_en_i(drv_en_o), .tx_fct_i(tx_fct_o),
    .lrx_ready_i(lrx_ready_o), .ltx_valid_i(ltx_valid_o), .ltx_data_i(ltx_data_o),
    .stall_i(stall), .fail_i(fail), .lrx_valid_o(lrx_valid_i), .lrx_data_o(lrx_data_i),
    .ltx_ready_o(ltx_ready_i), .got_null_o(got_null_i), .got_fct_o(got_fct_i),
    .link_err_o(link_err_i));

  // ======
  // clocks, link clock offset so edges never coincide
  initial
  begin
    clk_i = 0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial
  begin
    spw_clk_i = 0;
    #1.3;
    forever #80 spw_clk_i = ~spw_clk_i;
  end

  // ======
  // shared helpers
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic send(input int p, input logic [SYM_W-1:0] s[$]);
    foreach (s[i])
      u_far.src_q[p].push_back(s[i]);
  endtask
  // bounded wait for a packet, then compare each symbol
  task automatic expect_q(input int p, input logic [SYM_W-1:0] e[$]);
    int n;
    n = 0;
    while (u_far.snk_q[p].size() < e.size() && n < 4000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("rx count", 32'(u_far.snk_q[p].size()), 32'(e.size()));
    foreach (e[i])
      chk("symbol", u_far.snk_q[p][i], e[i]);
    u_far.snk_q[p].delete();
  endtask
  task automatic tbl(input logic [7:0] a, input logic [NP-1:0] m, input logic d);
    rt_wr_i      <= 1'b1;
    rt_wr_addr_i <= a;
    rt_wr_mask_i <= m;
    rt_wr_del_i  <= d;
    rt_rd_addr_i <= a;
    @(posedge clk_i);
    rt_wr_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("table mask", rt_rd_mask_o, m);
    chk("table del", rt_rd_del_o, d);
  endtask

  // ======
  // scenarios
  task automatic s_logic();
    tbl(8'h40, 5'h08, 1'b1);
    tbl(8'hff, 5'h02, 1'b0);
    tbl(8'h02, 5'h10, 1'b0);
    send(2, {9'h040, 9'h011, 9'h100});
    expect_q(3, {9'h011, 9'h100});
    send(4, {9'h0ff, 9'h012, 9'h100});
    expect_q(1, {9'h0ff, 9'h012, 9'h100});
  endtask
  // path byte ignores table entry 0x02
  task automatic s_path();
    send(1, {9'h002, 9'h003, 9'h0aa, 9'h100});
    expect_q(2, {9'h003, 9'h0aa, 9'h100});
    send(3, {9'h000, 9'h055, 9'h100});
    expect_q(0, {9'h055, 9'h100});
  endtask
  task automatic s_mcast();
    tbl(8'h50, 5'h0c, 1'b1);
    send(1, {9'h050, 9'h021, 9'h100});
    expect_q(2, {9'h021, 9'h100});
    expect_q(3, {9'h021, 9'h100});
  endtask
  task automatic s_cross();
    send(1, {9'h002, 9'h031, 9'h100});
    send(2, {9'h001, 9'h032, 9'h100});
    expect_q(2, {9'h031, 9'h100});
    expect_q(1, {9'h032, 9'h100});
    send(3, {9'h004, 9'h042, 9'h100});
    send(2, {9'h004, 9'h041, 9'h100});
    expect_q(4, {9'h041, 9'h100, 9'h042, 9'h100});
  endtask
  // stalled output: queues fill, time-out ends with error marker
  task automatic s_ovr();
    logic [SYM_W-1:0] s[$];
    int               n;
    s = {9'h002};
    for (int i = 0; i < 150; i++)
      s.push_back(9'(i));
    s.push_back(9'h100);
    ovr_to_en_i <= 5'h02;
    stall[2]    <= 1'b1;
    send(1, s);
    repeat (6000) @(posedge clk_i);
    chk("rx full", lrx_ready_o[1], 1'b0);
    chk("out busy", out_busy_o, 5'h04);
    stall[2] <= 1'b0;
    n = 0;
    while ((u_far.snk_q[2].size() == 0 || u_far.snk_q[2][$] !== SYM_EEP) && n < 4000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("error marker", u_far.snk_q[2][$], SYM_EEP);
    repeat (3000) @(posedge clk_i);
    u_far.snk_q[2].delete();
    ovr_to_en_i <= '0;
    send(1, {9'h002, 9'h066, 9'h100});
    expect_q(2, {9'h066, 9'h100});
  endtask
  task automatic s_link();
    port_link_disable_bit_i <= 5'h10;
    fail[4]                 <= 1'b1;
    repeat (400) @(posedge clk_i);
    chk("driver off", drv_en_o[4], 1'b0);
    port_link_disable_bit_i <= '0;
    fail[4]                 <= 1'b0;
    repeat (3000) @(posedge clk_i);
    chk("retry wait", link_run_o[4], 1'b0);
    repeat (3000) @(posedge clk_i);
    chk("relinked", link_run_o[4], 1'b1);
    router_config_reset_bit_i <= 1'b1;
    autostart_i               <= 5'h0f;
    @(posedge clk_i);
    router_config_reset_bit_i <= 1'b0;
    repeat (3000) @(posedge clk_i);
    chk("first start", link_run_o, 5'h0f);
    autostart_i <= '1;
    repeat (400) @(posedge clk_i);
    chk("autostart", link_run_o, 5'h1f);
  endtask

  // ======
  // main sequence
  initial
  begin
    {rst_i, ce_i, autostart_i} = '1;
    {router_config_reset_bit_i, port_link_disable_bit_i, ovr_to_en_i, stall, fail} = '0;
    {rt_wr_i, rt_wr_addr_i, rt_wr_mask_i, rt_wr_del_i, rt_rd_addr_i, err_count, checks} = '0;
    repeat (6) @(posedge spw_clk_i);
    @(posedge clk_i);
    rst_i <= 0;
    repeat (3000) @(posedge clk_i);
    chk("link up", link_run_o, 5'h1f);
    s_logic();
    s_path();
    s_mcast();
    s_cross();
    s_ovr();
    s_link();
    conclude();
  end

  // hang guard
  initial
  begin
    repeat (80000) @(posedge clk_i);
    err_count++;
    conclude();
  end
endmodule

// ==== verif/swrc_checker.sv ====
// port-level assertions for the routing core
`timescale 1ns/1ps
module swrc_checker
  import swrc_pkg::*;
(
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic          spw_clk_i,
  input wire logic          rt_wr_i,
  input wire logic [7:0]    rt_wr_addr_i,
  input wire logic [NP-1:0] rt_wr_mask_i,
  input wire logic          rt_wr_del_i,
  input wire logic [7:0]    rt_rd_addr_i,
  input wire logic [NP-1:0] rt_rd_mask_o,
  input wire logic          rt_rd_del_o,
  input wire logic          router_config_reset_bit_i,
  input wire logic [NP-1:0] port_link_disable_bit_i,
  input wire logic [NP-1:0] link_err_i,
  input wire logic [NP-1:0] out_busy_o,
  input wire logic [NP-1:0] drv_en_o,
  input wire logic [NP-1:0] tx_null_o,
  input wire logic [NP-1:0] tx_fct_o
);
  // ======
  // table and routing state, core clock
  property p_rd_zero;
    @(posedge clk_i) disable iff (rst_i)
      rt_rd_addr_i == 8'h00 |=> rt_rd_mask_o == '0 && !rt_rd_del_o;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("address zero read back not empty");
  property p_rd_write;
    @(posedge clk_i) disable iff (rst_i)
      (rt_wr_i && rt_wr_addr_i != 8'h00) ##1 (!rt_wr_i && rt_rd_addr_i == $past(rt_wr_addr_i))
      |=> rt_rd_mask_o == $past(rt_wr_mask_i, 2) && rt_rd_del_o == $past(rt_wr_del_i, 2);
  endproperty
  a_rd_write: assert property (p_rd_write)
    else $error("table entry read back differs from write");
  property p_cfg_busy;
    @(posedge clk_i) disable iff (rst_i)
      router_config_reset_bit_i |-> ##2 out_busy_o == '0;
  endproperty
  a_cfg_busy: assert property (p_cfg_busy)
    else $error("outputs still held after router reset");
  // slow link clock, so the window is long
  property p_cfg_pd;
    @(posedge clk_i) disable iff (rst_i)
      router_config_reset_bit_i |-> ##[1:400] drv_en_o == '0;
  endproperty
  a_cfg_pd: assert property (p_cfg_pd)
    else $error("router reset did not power ports down");
  // ======
  // link start, link clock, one set per port
  for (genvar k = 0; k < NP; k++)
  begin : g_port
    property p_null_drv;
      @(posedge spw_clk_i) disable iff (rst_i)
        tx_null_o[k] |-> drv_en_o[k] && $past(drv_en_o[k], 2);
    endproperty
    a_null_drv: assert property (p_null_drv)
      else $error("null sent before driver was on");
    property p_null_once;
      @(posedge spw_clk_i) disable iff (rst_i)
        tx_null_o[k] |=> !tx_null_o[k];
    endproperty
    a_null_once: assert property (p_null_once)
      else $error("more than one null requested");
    property p_null_fct;
      @(posedge spw_clk_i) disable iff (rst_i)
        (tx_null_o[k] && !link_err_i[k]) |-> ##[1:2] tx_fct_o[k];
    endproperty
    a_null_fct: assert property (p_null_fct)
      else $error("no flow control after the null");
    property p_dis_pd;
      @(posedge spw_clk_i) disable iff (rst_i)
        (link_err_i[k] && port_link_disable_bit_i[k]) [*4] |-> ##[1:4] !drv_en_o[k];
    endproperty
    a_dis_pd: assert property (p_dis_pd)
      else $error("disabled port kept its driver on");
  end
endmodule

bind swrc_core swrc_checker u_chk (.clk_i, .rst_i, .spw_clk_i, .rt_wr_i, .rt_wr_addr_i,
  .rt_wr_mask_i, .rt_wr_del_i, .rt_rd_addr_i, .rt_rd_mask_o, .rt_rd_del_o,
  .router_config_reset_bit_i, .port_link_disable_bit_i, .link_err_i, .out_busy_o,
  .drv_en_o, .tx_null_o, .tx_fct_o);

// ==== verif/swrc_far_end.sv ====
// far-end link partner model for every port of the routing core
`timescale 1ns/1ps
module swrc_far_end
  import swrc_pkg::*;
#(
  parameter int RETRY_CYC = 120
)
(
  input  wire logic                     spw_clk_i,
  input  wire logic [NP-1:0]            drv_en_i,
  input  wire logic [NP-1:0]            tx_fct_i,
  input  wire logic [NP-1:0]            lrx_ready_i,
  input  wire logic [NP-1:0]            ltx_valid_i,
  input  wire logic [NP-1:0][SYM_W-1:0] ltx_data_i,
  input  wire logic [NP-1:0]            stall_i,
  input  wire logic [NP-1:0]            fail_i,
  output logic      [NP-1:0]            lrx_valid_o,
  output logic      [NP-1:0][SYM_W-1:0] lrx_data_o,
  output logic      [NP-1:0]            ltx_ready_o,
  output logic      [NP-1:0]            got_null_o,
  output logic      [NP-1:0]            got_fct_o,
  output logic      [NP-1:0]            link_err_o
);
  // ======
  // symbols to send and symbols seen, per port
  logic [SYM_W-1:0] src_q[NP][$];
  logic [SYM_W-1:0] snk_q[NP][$];
  int               wait_cnt[NP];

  // quiet link at time zero
  initial
  begin
    {lrx_valid_o, lrx_data_o, ltx_ready_o, got_null_o, got_fct_o, link_err_o} = '0;
    wait_cnt    = '{default: 0};
  end

  // ======
  // symbols held until taken; idle data inverted
  always @(posedge spw_clk_i)
  begin
    for (int p = 0; p < NP; p++)
    begin
      if (lrx_valid_o[p] && lrx_ready_i[p])
        void'(src_q[p].pop_front());
      lrx_valid_o[p] <= src_q[p].size() > 0;
      lrx_data_o[p]  <= (src_q[p].size() > 0) ? src_q[p][0] : ~lrx_data_o[p];
      if (ltx_valid_i[p] && ltx_ready_o[p])
        snk_q[p].push_back(ltx_data_i[p]);
      ltx_ready_o[p] <= !stall_i[p];
      // link start held, retry after a failure
      link_err_o[p] <= fail_i[p];
      if (fail_i[p])
        wait_cnt[p] <= RETRY_CYC;
      else if (wait_cnt[p] > 0)
        wait_cnt[p] <= wait_cnt[p] - 1;
      got_null_o[p] <= drv_en_i[p] && !fail_i[p] && wait_cnt[p] == 0;
      got_fct_o[p]  <= got_null_o[p] && tx_fct_i[p];
    end
  end
endmodule

// ==== verilog/swrc_core.sv ====
// spacewire wormhole routing core
// Notes on behaviour
// - head 0x01-0x1F: path address
// - head 0x20-0xFF: logical address via table
// - head zero: configuration port
// - only the head byte routes
// - path headers always deleted
// - logical header deletion chosen per entry
// - 255 table entries, one per nonzero address
// - entry holds output mask and deletion flag
// - one connection in and one out per port
// - source and sink at once, to different ports
// - 64 entry receive and transmit queue per port
// - queues decouple link speeds
// - connection holds until packet end moves or spills
// - multicast holds free targets, sends when all held
// - lower input port wins outputs
// - overrun time-out drops packet, queues error end marker
// - autostart with NULL seen: one NULL, then flow control
// - router reset, or error reset when disabled: power-down
`timescale 1ns/1ps

// ============================================================
// dual clock queue, gray pointers, registered read stage
module swrc_afifo
  import swrc_pkg::*;
(
  input  wire logic             wclk_i,
  input  wire logic             wrst_i,
  input  wire logic             wce_i,
  input  wire logic             wvalid_i,
  input  wire logic [SYM_W-1:0] wdata_i,
  output logic                  wready_o,
  input  wire logic             rclk_i,
  input  wire logic             rrst_i,
  input  wire logic             rce_i,
  output logic                  rvalid_o,
  output logic [SYM_W-1:0]      rdata_o,
  input  wire logic             rready_i
);
  logic [SYM_W-1:0] mem_reg [FIFO_DEPTH];
  logic [FIFO_AW:0] wbin_reg;
  logic [FIFO_AW:0] wgray_reg;
  logic [FIFO_AW:0] rbin_reg;
  logic [FIFO_AW:0] rgray_reg;
  logic [FIFO_AW:0] rg_s1_reg;
  logic [FIFO_AW:0] rg_s2_reg;
  logic [FIFO_AW:0] wg_s1_reg;
  logic [FIFO_AW:0] wg_s2_reg;
  logic [FIFO_AW:0] wbin_next;
  logic [FIFO_AW:0] wgray_next;
  logic [FIFO_AW:0] rbin_next;
  logic             wr_en;
  logic             rd_en;

  // pointer arithmetic
  assign wr_en      = wvalid_i & wready_o;
  assign wbin_next  = wbin_reg + {{FIFO_AW{1'b0}}, wr_en};
  assign wgray_next = wbin_next ^ (wbin_next >> 1);
  assign rd_en      = (rgray_reg != wg_s2_reg) & (~rvalid_o | rready_i);
  assign rbin_next  = rbin_reg + {{FIFO_AW{1'b0}}, rd_en};

  // write side; ready is a flop for clean back-pressure
  always_ff @(posedge wclk_i)
  begin
    if (wrst_i)
    begin
      wbin_reg  <= '0;
      wgray_reg <= '0;
      wready_o  <= 1'b1;
      rg_s1_reg <= '0;
      rg_s2_reg <= '0;
    end
    else if (wce_i)
    begin
      wbin_reg  <= wbin_next;
      wgray_reg <= wgray_next;
      wready_o  <= wgray_next !=
                   {~rg_s2_reg[FIFO_AW:FIFO_AW-1], rg_s2_reg[FIFO_AW-2:0]};
      rg_s1_reg <= rgray_reg;
      rg_s2_reg <= rg_s1_reg;
    end
  end

  // storage
  always_ff @(posedge wclk_i)
  begin
    if (wce_i && wr_en)
      mem_reg[wbin_reg[FIFO_AW-1:0]] <= wdata_i;
  end

  // read side with one output register
  always_ff @(posedge rclk_i)
  begin
    if (rrst_i)
    begin
      rbin_reg  <= '0;
      rgray_reg <= '0;
      rvalid_o  <= 1'b0;
      rdata_o   <= '0;
      wg_s1_reg <= '0;
      wg_s2_reg <= '0;
    end
    else if (rce_i)
    begin
      rbin_reg  <= rbin_next;
      rgray_reg <= rbin_next ^ (rbin_next >> 1);
      wg_s1_reg <= wgray_reg;
      wg_s2_reg <= wg_s1_reg;
      if (rd_en)
      begin
        rdata_o  <= mem_reg[rbin_reg[FIFO_AW-1:0]];
        rvalid_o <= 1'b1;
      end
      else if (rready_i)
        rvalid_o <= 1'b0;
    end
  end
endmodule

// ============================================================
// routing core top
module swrc_core
  import swrc_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  input  wire logic                       spw_clk_i,
  input  wire logic [NP-1:0]              lrx_valid_i,
  input  wire logic [NP-1:0][SYM_W-1:0]   lrx_data_i,
  output logic      [NP-1:0]              lrx_ready_o,
  output logic      [NP-1:0]              ltx_valid_o,
  output logic      [NP-1:0][SYM_W-1:0]   ltx_data_o,
  input  wire logic [NP-1:0]              ltx_ready_i,
  input  wire logic [NP-1:0]              got_null_i,
  input  wire logic [NP-1:0]              got_fct_i,
  input  wire logic [NP-1:0]              link_err_i,
  output logic      [NP-1:0]              drv_en_o,
  output logic      [NP-1:0]              tx_null_o,
  output logic      [NP-1:0]              tx_fct_o,
  output logic      [NP-1:0]              link_run_o,
  input  wire logic [NP-1:0]              autostart_i,
  input  wire logic [NP-1:0]              port_link_disable_bit_i,
  input  wire logic                       router_config_reset_bit_i,
  input  wire logic [NP-1:0]              ovr_to_en_i,
  input  wire logic                       rt_wr_i,
  input  wire logic [7:0]                 rt_wr_addr_i,
  input  wire logic [NP-1:0]              rt_wr_mask_i,
  input  wire logic                       rt_wr_del_i,
  input  wire logic [7:0]                 rt_rd_addr_i,
  output logic      [NP-1:0]              rt_rd_mask_o,
  output logic                            rt_rd_del_o,
  output logic      [NP-1:0]              out_busy_o
);
  // core domain
  logic [NP-1:0]             rt_mask_mem [1:RT_LAST];
  logic                      rt_del_mem  [1:RT_LAST];
  swrc_in_st_t               st_reg      [NP];
  logic [NP-1:0]             want_reg    [NP];
  logic [NP-1:0]             held_reg    [NP];
  logic [TO_W-1:0]           cnt_reg     [NP];
  logic [NP-1:0]             dec_mask    [NP];
  logic [NP-1:0]             claim       [NP];
  logic [SYM_W-1:0]          pdat        [NP];
  logic [NP-1:0][SYM_W-1:0]  rx_d;
  logic [NP-1:0][SYM_W-1:0]  tx_wd;
  logic [NP-1:0]             rx_v;
  logic [NP-1:0]             pop;
  logic [NP-1:0]             push;
  logic [NP-1:0]             rel;
  logic [NP-1:0]             blk;
  logic [NP-1:0]             dec_del;
  logic [NP-1:0]             tx_wv;
  logic [NP-1:0]             tx_wrdy;
  logic [NP-1:0]             busy_v;
  logic [NP-1:0]             busy_now;
  logic [7:0]                hdr;
  logic                      core_rst;
  logic                      crst_tgl_reg;
  // link domain
  swrc_link_st_t             ls_reg      [NP];
  logic [NP-1:0]             ld_s1_reg;
  logic [NP-1:0]             ld_s2_reg;
  logic [NP-1:0]             as_s1_reg;
  logic [NP-1:0]             as_s2_reg;
  logic                      lrst_s1_reg;
  logic                      lrst_s2_reg;
  logic                      lce_s1_reg;
  logic                      lce_s2_reg;
  logic                      ct_s1_reg;
  logic                      ct_s2_reg;
  logic                      ct_s3_reg;
  logic                      lcfg_rst;

  // a write to the reset bit restarts the routing state as well
  assign core_rst = rst_i | router_config_reset_bit_i;

  // ==========================================================
  // per-port queues between links and switch matrix
  for (genvar p = 0; p < NP; p++)
  begin : g_port
    swrc_afifo u_rxq
    (
      .wclk_i   (spw_clk_i),
      .wrst_i   (lrst_s2_reg),
      .wce_i    (lce_s2_reg),
      .wvalid_i (lrx_valid_i[p]),
      .wdata_i  (lrx_data_i[p]),
      .wready_o (lrx_ready_o[p]),
      .rclk_i   (clk_i),
      .rrst_i   (rst_i),
      .rce_i    (ce_i),
      .rvalid_o (rx_v[p]),
      .rdata_o  (rx_d[p]),
      .rready_i (pop[p])
    );
    swrc_afifo u_txq
    (
      .wclk_i   (clk_i),
      .wrst_i   (rst_i),
      .wce_i    (ce_i),
      .wvalid_i (tx_wv[p]),
      .wdata_i  (tx_wd[p]),
      .wready_o (tx_wrdy[p]),
      .rclk_i   (spw_clk_i),
      .rrst_i   (lrst_s2_reg),
      .rce_i    (lce_s2_reg),
      .rvalid_o (ltx_valid_o[p]),
      .rdata_o  (ltx_data_o[p]),
      .rready_i (ltx_ready_i[p])
    );
  end

  // ==========================================================
  // routing table on the core clock
  always_ff @(posedge clk_i)
  begin
    if (ce_i && rt_wr_i && rt_wr_addr_i != ADDR_CFG)
    begin
      rt_mask_mem[rt_wr_addr_i] <= rt_wr_mask_i;
      rt_del_mem[rt_wr_addr_i]  <= rt_wr_del_i;
    end
  end

  // readback of one entry; address zero reads as empty
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rt_rd_mask_o <= '0;
      rt_rd_del_o  <= 1'b0;
    end
    else if (ce_i)
    begin
      rt_rd_mask_o <= (rt_rd_addr_i == ADDR_CFG) ? '0 : rt_mask_mem[rt_rd_addr_i];
      rt_rd_del_o  <= (rt_rd_addr_i == ADDR_CFG) ? 1'b0 : rt_del_mem[rt_rd_addr_i];
    end
  end

  // ==========================================================
  // decode, output arbitration and byte movement
  always_comb
  begin
    hdr    = '0;
    busy_v = '0;
    for (int i = 0; i < NP; i++)
      busy_v = busy_v | held_reg[i];
    busy_now = busy_v;
    for (int i = 0; i < NP; i++)
    begin
      // only the head byte is examined, later address bytes pass as data
      hdr         = rx_d[i][7:0];
      dec_mask[i] = '0;
      dec_del[i]  = 1'b1;
      if (hdr == ADDR_CFG)
        dec_mask[i][0] = 1'b1;
      else if (hdr <= PHYS_MAX)
      begin
        // unknown path ports leave the mask empty and the packet spills
        if (hdr < NP_B)
          dec_mask[i][hdr[PORT_W-1:0]] = 1'b1;
      end
      else
      begin
        dec_mask[i] = rt_mask_mem[hdr];
        dec_del[i]  = rt_del_mem[hdr];
      end
      blk[i]   = |(held_reg[i] & ~tx_wrdy);
      pop[i]   = 1'b0;
      push[i]  = 1'b0;
      rel[i]   = 1'b0;
      claim[i] = '0;
      pdat[i]  = rx_d[i];
      case (st_reg[i])
        IN_HDR:
          // path headers always dropped, logical ones as the entry says
          pop[i] = rx_v[i] & (rx_d[i][8] | (dec_del[i] & (|dec_mask[i])));
        IN_ALLOC:
        begin
          // ascending loop: lower input numbers see free outputs first
          claim[i] = want_reg[i] & ~held_reg[i] & ~busy_v;
          busy_v   = busy_v | claim[i];
        end
        IN_XFER:
        begin
          pop[i]  = rx_v[i] & ~blk[i];
          push[i] = rx_v[i] & ~blk[i];
          rel[i]  = rx_v[i] & ~blk[i] & rx_d[i][8];
        end
        IN_EEPW:
        begin
          push[i] = ~blk[i];
          pdat[i] = SYM_EEP;
          rel[i]  = ~blk[i];
        end
        IN_SPILL:
          pop[i] = rx_v[i];
        default:
          pop[i] = 1'b0;
      endcase
    end
  end

  // switch matrix: each output takes bytes from its single owner
  always_comb
  begin
    tx_wv = '0;
    tx_wd = '0;
    for (int o = 0; o < NP; o++)
    begin
      for (int i = 0; i < NP; i++)
      begin
        if (held_reg[i][o] && push[i])
        begin
          tx_wv[o] = 1'b1;
          tx_wd[o] = pdat[i];
        end
      end
    end
  end

  // per-input connection state
  always_ff @(posedge clk_i)
  begin
    if (core_rst)
    begin
      for (int i = 0; i < NP; i++)
      begin
        st_reg[i]   <= IN_HDR;
        want_reg[i] <= '0;
        held_reg[i] <= '0;
        cnt_reg[i]  <= '0;
      end
    end
    else if (ce_i)
    begin
      for (int i = 0; i < NP; i++)
      begin
        held_reg[i] <= rel[i] ? '0 : (held_reg[i] | claim[i]);
        // stall timer only runs while a waiting byte in transfer cannot move
        if (st_reg[i] == IN_XFER && rx_v[i] && blk[i] && ovr_to_en_i[i])
          cnt_reg[i] <= cnt_reg[i] + 12'h001;
        else
          cnt_reg[i] <= '0;
        case (st_reg[i])
          IN_HDR:
          begin
            if (rx_v[i] && !rx_d[i][8])
            begin
              want_reg[i] <= dec_mask[i];
              st_reg[i]   <= (|dec_mask[i]) ? IN_ALLOC : IN_SPILL;
            end
          end
          IN_ALLOC:
          begin
            // nothing is sent until every target is held
            if ((held_reg[i] | claim[i]) == want_reg[i])
              st_reg[i] <= IN_XFER;
          end
          IN_XFER:
          begin
            if (rel[i])
              st_reg[i] <= IN_HDR;
            else if (cnt_reg[i] == OVR_TO_LAST && blk[i])
              st_reg[i] <= IN_EEPW;
          end
          IN_EEPW:
          begin
            if (rel[i])
              st_reg[i] <= IN_SPILL;
          end
          IN_SPILL:
          begin
            if (rx_v[i] && rx_d[i][8])
              st_reg[i] <= IN_HDR;
          end
          default:
            st_reg[i] <= IN_HDR;
        endcase
      end
    end
  end

  // busy view and reset-bit event toggle for the link side
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_busy_o   <= '0;
      crst_tgl_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      out_busy_o   <= busy_now;
      crst_tgl_reg <= crst_tgl_reg ^ router_config_reset_bit_i;
    end
  end

  // ==========================================================
  // link clock domain: synchronisers
  always_ff @(posedge spw_clk_i)
  begin
    lrst_s1_reg <= rst_i;
    lrst_s2_reg <= lrst_s1_reg;
    lce_s1_reg  <= ce_i;
    lce_s2_reg  <= lce_s1_reg;
    ld_s1_reg   <= port_link_disable_bit_i;
    ld_s2_reg   <= ld_s1_reg;
    as_s1_reg   <= autostart_i;
    as_s2_reg   <= as_s1_reg;
    ct_s1_reg   <= crst_tgl_reg;
    ct_s2_reg   <= ct_s1_reg;
    ct_s3_reg   <= ct_s2_reg;
  end

  // a toggle edge marks one reset-bit write seen on the link clock
  assign lcfg_rst = ct_s2_reg ^ ct_s3_reg;

  // link start control per port
  always_ff @(posedge spw_clk_i)
  begin
    if (lrst_s2_reg || lcfg_rst)
    begin
      for (int p = 0; p < NP; p++)
        ls_reg[p] <= LS_PD;
      drv_en_o   <= '0;
      tx_null_o  <= '0;
      tx_fct_o   <= '0;
      link_run_o <= '0;
    end
    else if (lce_s2_reg)
    begin
      for (int p = 0; p < NP; p++)
      begin
        tx_null_o[p] <= 1'b0;
        if (ls_reg[p] != LS_PD && ls_reg[p] != LS_ERR_RST && link_err_i[p])
        begin
          ls_reg[p]     <= LS_ERR_RST;
          tx_fct_o[p]   <= 1'b0;
          link_run_o[p] <= 1'b0;
        end
        else
        begin
          case (ls_reg[p])
            LS_PD:
            begin
              // driver comes up two link cycles ahead of any NULL
              if (!ld_s2_reg[p])
              begin
                ls_reg[p]   <= LS_ERR_RST;
                drv_en_o[p] <= 1'b1;
              end
            end
            LS_ERR_RST:
            begin
              if (ld_s2_reg[p])
              begin
                ls_reg[p]   <= LS_PD;
                drv_en_o[p] <= 1'b0;
              end
              else
                ls_reg[p] <= LS_READY;
            end
            LS_READY:
            begin
              if (as_s2_reg[p] && got_null_i[p])
              begin
                ls_reg[p]    <= LS_START;
                tx_null_o[p] <= 1'b1;
              end
            end
            LS_START:
            begin
              // exactly one NULL, flow control tokens follow
              ls_reg[p]   <= LS_FCT;
              tx_fct_o[p] <= 1'b1;
            end
            LS_FCT:
            begin
              if (got_fct_i[p])
              begin
                ls_reg[p]     <= LS_RUN;
                tx_fct_o[p]   <= 1'b0;
                link_run_o[p] <= 1'b1;
              end
            end
            LS_RUN:
              link_run_o[p] <= 1'b1;
            default:
              ls_reg[p] <= LS_PD;
          endcase
        end
      end
    end
  end
endmodule

// ==== verilog/swrc_pkg.sv ====
// constants and types shared by the spacewire wormhole routing core
package swrc_pkg;
  // ==========================================================
  // ports and symbols
  localparam int NP         = 5;    // port 0 is the configuration port
  localparam int PORT_W     = 3;
  localparam int SYM_W      = 9;    // bit 8 marks an end of packet
  localparam int FIFO_AW    = 6;
  localparam int FIFO_DEPTH = 64;
  localparam int RT_LAST    = 255;
  localparam logic [7:0]       ADDR_CFG = 8'h00;
  localparam logic [7:0]       PHYS_MAX = 8'h1F;
  localparam logic [7:0]       NP_B     = 8'(NP);
  localparam logic [SYM_W-1:0] SYM_EEP  = 9'h101;

  // ==========================================================
  // timing
  localparam int CLK_PS     = 5000;
  localparam int OVR_TO_NS  = 10000;
  // longest wait, so the cycle count rounds down
  localparam int OVR_TO_CYC = (OVR_TO_NS * 1000) / CLK_PS;
  localparam int TO_W       = 12;
  localparam logic [TO_W-1:0] OVR_TO_LAST = TO_W'(OVR_TO_CYC - 1);

  // ==========================================================
  // state types
  typedef enum logic [2:0] {IN_HDR, IN_ALLOC, IN_XFER, IN_EEPW, IN_SPILL} swrc_in_st_t;
  typedef enum logic [2:0] {LS_PD, LS_ERR_RST, LS_READY, LS_START, LS_FCT, LS_RUN}
    swrc_link_st_t;
endpackage
